/* File: hw/pgc_top.sv */
// pwm generator control and status registers behind an ahb-lite slave
// How it works
// R1: fault event sets fault_pending; writing fault_irq_en zero clears it.
// R2: limit event sets limit_pending; writing limit_irq_en zero clears it.
// R3: trigger event sets trigger_pending; writing trigger_irq_en zero clears it.
// R4: with trigger_irq_en set, every trigger event raises an interrupt request.
// R5: software clears status here and in the interrupt controller flag.
// R6: independent_base_sel picks phase period, else primary period.
// R7: master_duty_sel picks shared duty, else own duty register.
// R8: software leaves mode bits alone after pwm_module_on is set.
// R9: deadtime polarity counts only when deadtime_ctrl equals binary 11.
// R10: center aligned mode needs independent_base_sel; otherwise ignored.
// R11: external period reset needs independent base and limit_mode_sel zero.
// R12: secondary period is 16 bits, reset 0xFFF8.
// R13: secondary event compare count is 16 bits, reset zero, matched against timer.
// R14: bits 14..8 select compensation input 5: 0 low, 1 comparator, 124 remap.
// R15: bits 6..0 select compensation input 4 likewise; bits 15, 7 read zero.
// R16: status bits hardware set/cleared; enables and selects read/write, reset zero.
// R17: one interrupt output: OR of pending bits gated by enables; here irq is also masked per bit by irq_mask.
//
// Implementation choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
module pgc_top
  import pgc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic fault_event,
  input wire logic limit_event,
  input wire logic trigger_event,
  input wire logic limit_mode_sel,
  input wire logic pwm_module_on,
  input wire logic [15:0] secondary_master_timer,
  input wire logic comparator_one,
  input wire logic [124:2] remap_inputs,
  output logic irq,
  output logic trigger_irq_req,
  output logic [15:0] active_period,
  output logic [15:0] active_duty,
  output logic center_aligned_on,
  output logic ext_period_reset_on,
  output logic deadtime_polarity_eff,
  output logic secondary_event_match,
  output logic comp_in4,
  output logic comp_in5
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [15:0] control;
    logic [15:0] sec_period;
    logic [15:0] sec_compare;
    logic [15:0] comp_select;
    logic [15:0] phase_period;
    logic [15:0] primary_period;
    logic [15:0] shared_duty;
    logic [15:0] own_duty;
    logic [2:0] irq_mask;
    logic [31:0] rdata;
    logic irq;
    logic trig_req;
    logic [15:0] act_period;
    logic [15:0] act_duty;
    logic center_on;
    logic ext_reset_on;
    logic dt_pol;
    logic sev_match;
    logic in4;
    logic in5;
    logic bus_rdy;
    logic bus_err;
  } pgc_state_t;

  pgc_state_t st;
  pgc_state_t next_st;

  logic addr_ok;
  assign addr_ok = hsel && hready && htrans == PGC_HTRANS_NONSEQ;

  // combinational pin mux: code 0 low, 1 comparator, 2..124 remap
  function automatic logic pgc_route(input logic [6:0] code, input logic cmp, input logic [124:2] pins);
    logic r;
    r = 1'b0;
    if (code == PGC_SEL_COMPARATOR) begin
      r = cmp;
    end else if (code != PGC_SEL_TIED_LOW && code <= PGC_SEL_REMAP_124) begin
      r = pins[code];
    end
    return r;
  endfunction : pgc_route

  always_comb begin
    logic [15:0] wd;
    logic [15:0] ctl;
    logic [2:0] pend;
    wd = hwdata[15:0];
    ctl = st.control;
    pend = 3'b000;
    next_st = st;
    next_st.wr_pend = 1'b0;
    // zero wait states; response is always okay
    next_st.bus_rdy = 1'b1;
    next_st.bus_err = 1'b0;
    // ------------------------------------------------------------
    // register writes (data phase)
    // ------------------------------------------------------------
    if (st.wr_pend) begin
      case (st.wr_addr)
        // R16: only enable and select bits writable
        PGC_OFS_CONTROL: ctl = (ctl & ~PGC_CTRL_WMASK) | (wd & PGC_CTRL_WMASK);
        // R12: secondary period value
        PGC_OFS_SEC_PERIOD: next_st.sec_period = wd;
        // R13: secondary compare count
        PGC_OFS_SEC_COMPARE: next_st.sec_compare = wd;
        // R15: unimplemented bits kept zero
        PGC_OFS_COMP_SELECT: next_st.comp_select = wd & PGC_COMP_SEL_MASK;
        PGC_OFS_PERIODS: begin
          next_st.phase_period = hwdata[31:16];
          next_st.primary_period = wd;
        end
        PGC_OFS_DUTIES: begin
          next_st.shared_duty = hwdata[31:16];
          next_st.own_duty = wd;
        end
        PGC_OFS_IRQ_MASK: next_st.irq_mask = hwdata[2:0];
        default: ;
      endcase
    end
    // R1: fault pending, cleared by disabled enable, which also blocks the set
    // R2: limit pending likewise
    // R3: trigger pending likewise
    pend = {ctl[PGC_B_FAULT_PEND] & ctl[PGC_B_FAULT_IEN],
            ctl[PGC_B_LIMIT_PEND] & ctl[PGC_B_LIMIT_IEN],
            ctl[PGC_B_TRIG_PEND] & ctl[PGC_B_TRIG_IEN]};
    pend = pend | {fault_event & ctl[PGC_B_FAULT_IEN],
                   limit_event & ctl[PGC_B_LIMIT_IEN],
                   trigger_event & ctl[PGC_B_TRIG_IEN]};
    ctl[PGC_B_FAULT_PEND] = pend[2];
    ctl[PGC_B_LIMIT_PEND] = pend[1];
    ctl[PGC_B_TRIG_PEND] = pend[0];
    next_st.control = ctl;
    // R17: single masked interrupt output
    next_st.irq = |(pend & ~next_st.irq_mask);
    // R4: one request per trigger event
    next_st.trig_req = trigger_event & st.control[PGC_B_TRIG_IEN];
    // R6: period source
    next_st.act_period = st.control[PGC_B_INDEP_BASE] ? st.phase_period : st.primary_period;
    // R7: duty source
    next_st.act_duty = st.control[PGC_B_MASTER_DUTY] ? st.shared_duty : st.own_duty;
    // R10: center aligned only on independent base
    next_st.center_on = st.control[PGC_B_CENTER] & st.control[PGC_B_INDEP_BASE];
    // R11: external reset needs independent base and cycle-by-cycle off
    next_st.ext_reset_on = st.control[PGC_B_EXT_RESET] & st.control[PGC_B_INDEP_BASE] & ~limit_mode_sel;
    // R9: polarity effective only in compensation mode
    next_st.dt_pol = st.control[PGC_B_DT_POL]
                     & (st.control[PGC_B_DT_HI:PGC_B_DT_LO] == PGC_DT_COMP_MODE);
    // R13: compare against secondary timer
    next_st.sev_match = secondary_master_timer == st.sec_compare;
    // R14: input 5 routing
    next_st.in5 = pgc_route(st.comp_select[14:8], comparator_one, remap_inputs);
    // R15: input 4 routing
    next_st.in4 = pgc_route(st.comp_select[6:0], comparator_one, remap_inputs);
    // ------------------------------------------------------------
    // address phase and read data
    // ------------------------------------------------------------
    if (addr_ok) begin
      next_st.wr_pend = hwrite;
      next_st.wr_addr = haddr[7:0];
      next_st.rdata = 32'h0000_0000;
      // reads see state as of the address phase
      case (haddr[7:0])
        PGC_OFS_CONTROL: next_st.rdata = {16'h0000, st.control};
        PGC_OFS_SEC_PERIOD: next_st.rdata = {16'h0000, st.sec_period};
        PGC_OFS_SEC_COMPARE: next_st.rdata = {16'h0000, st.sec_compare};
        PGC_OFS_COMP_SELECT: next_st.rdata = {16'h0000, st.comp_select};
        PGC_OFS_PERIODS: next_st.rdata = {st.phase_period, st.primary_period};
        PGC_OFS_DUTIES: next_st.rdata = {st.shared_duty, st.own_duty};
        PGC_OFS_IRQ_MASK: next_st.rdata = {29'h0000_0000, st.irq_mask};
        PGC_OFS_MISC: next_st.rdata = {30'h0000_0000, pwm_module_on, limit_mode_sel};
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
      // R16: all control bits clear
      st.control <= PGC_RST_CONTROL;
      // R12: period resets to 0xFFF8
      st.sec_period <= PGC_RST_SEC_PERIOD;
      st.sec_compare <= PGC_RST_SEC_COMPARE;
      st.comp_select <= PGC_RST_COMP_SELECT;
      // slave shows ready even while in reset
      st.bus_rdy <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign hreadyout = st.bus_rdy;
  assign hresp = st.bus_err;
  assign hrdata = st.rdata;
  assign irq = st.irq;
  assign trigger_irq_req = st.trig_req;
  assign active_period = st.act_period;
  assign active_duty = st.act_duty;
  assign center_aligned_on = st.center_on;
  assign ext_period_reset_on = st.ext_reset_on;
  assign deadtime_polarity_eff = st.dt_pol;
  assign secondary_event_match = st.sev_match;
  assign comp_in4 = st.in4;
  assign comp_in5 = st.in5;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // R1: fault pending clears on the same edge as enable drops
  fault_clear_a: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    !st.control[PGC_B_FAULT_IEN] |-> !st.control[PGC_B_FAULT_PEND])
    else $error("fault pending set while disabled");
  // R2: limit event sets pending
  limit_set_a: assert property (@(posedge hclk) disable iff (!hresetn) // R2
    limit_event && next_st.control[PGC_B_LIMIT_IEN] |=> st.control[PGC_B_LIMIT_PEND])
    else $error("limit event lost");
  // R3: trigger pending needs enable
  trig_clear_a: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    st.control[PGC_B_TRIG_PEND] |-> st.control[PGC_B_TRIG_IEN])
    else $error("trigger pending without enable");
  // R4: request follows trigger event
  trig_request_a: assert property (@(posedge hclk) disable iff (!hresetn) // R4
    trigger_event && st.control[PGC_B_TRIG_IEN] |=> trigger_irq_req)
    else $error("trigger request missing");
  // R6: period source selection
  period_select_a: assert property (@(posedge hclk) disable iff (!hresetn) // R6
    $stable(st.control) && $stable(st.phase_period) && $stable(st.primary_period) |=>
    active_period == ($past(st.control[PGC_B_INDEP_BASE]) ? $past(st.phase_period) : $past(st.primary_period)))
    else $error("wrong period source");
  // R10: center aligned needs independent base
  center_gate_a: assert property (@(posedge hclk) disable iff (!hresetn) // R10
    !$past(st.control[PGC_B_INDEP_BASE]) |-> !center_aligned_on)
    else $error("center aligned without independent base");
  // R11: external reset gated by limit mode
  ext_reset_a: assert property (@(posedge hclk) disable iff (!hresetn) // R11
    $past(limit_mode_sel) |-> !ext_period_reset_on)
    else $error("external reset with limit mode set");
  // R9: polarity ignored outside mode 11
  dt_polarity_a: assert property (@(posedge hclk) disable iff (!hresetn) // R9
    deadtime_polarity_eff |-> $past(st.control[PGC_B_DT_HI:PGC_B_DT_LO]) == PGC_DT_COMP_MODE)
    else $error("polarity honoured outside mode");
  // R15: reserved select bits stay zero
  sel_reserved_a: assert property (@(posedge hclk) disable iff (!hresetn) // R15
    (st.comp_select & ~PGC_COMP_SEL_MASK) == 16'h0000)
    else $error("reserved select bit set");
  // R17: irq equals masked pending
  irq_level_a: assert property (@(posedge hclk) disable iff (!hresetn) // R17
    irq == |({st.control[PGC_B_FAULT_PEND], st.control[PGC_B_LIMIT_PEND],
              st.control[PGC_B_TRIG_PEND]} & ~st.irq_mask))
    else $error("irq does not match pending bits");
  // outputs are registered, so most checks look one edge after their cause
  // R1: fault event sets pending
  fault_set_a: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    fault_event && next_st.control[PGC_B_FAULT_IEN] |=> st.control[PGC_B_FAULT_PEND])
    else $error("fault event lost");
  // R2: limit pending clears with enable
  limit_clear_a: assert property (@(posedge hclk) disable iff (!hresetn) // R2
    !st.control[PGC_B_LIMIT_IEN] |-> !st.control[PGC_B_LIMIT_PEND])
    else $error("limit pending set while disabled");
  // R3: trigger event sets pending
  trig_set_a: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    trigger_event && next_st.control[PGC_B_TRIG_IEN] |=> st.control[PGC_B_TRIG_PEND])
    else $error("trigger event lost");
  // R4: no request without an event
  trig_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn) // R4
    !trigger_event |=> !trigger_irq_req)
    else $error("trigger request without event");
  // R4: no request while disabled
  trig_off_a: assert property (@(posedge hclk) disable iff (!hresetn) // R4
    !st.control[PGC_B_TRIG_IEN] |=> !trigger_irq_req)
    else $error("trigger request while disabled");
  // R7: duty source selection
  duty_select_a: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    $stable(st.control) && $stable(st.shared_duty) && $stable(st.own_duty) |=>
    active_duty == ($past(st.control[PGC_B_MASTER_DUTY]) ? $past(st.shared_duty) : $past(st.own_duty)))
    else $error("wrong duty source");
  // R9: polarity honoured in mode 11
  polarity_on_a: assert property (@(posedge hclk) disable iff (!hresetn) // R9
    st.control[PGC_B_DT_POL] && st.control[PGC_B_DT_HI:PGC_B_DT_LO] == PGC_DT_COMP_MODE |=> deadtime_polarity_eff)
    else $error("polarity not honoured in mode");
  // R10: center aligned on independent base
  center_on_a: assert property (@(posedge hclk) disable iff (!hresetn) // R10
    st.control[PGC_B_CENTER] && st.control[PGC_B_INDEP_BASE] |=> center_aligned_on)
    else $error("center aligned mode not taken");
  // R11: external reset needs independent base
  ext_base_a: assert property (@(posedge hclk) disable iff (!hresetn) // R11
    !st.control[PGC_B_INDEP_BASE] |=> !ext_period_reset_on)
    else $error("external reset without independent base");
  // R11: external reset taken when allowed
  ext_enable_a: assert property (@(posedge hclk) disable iff (!hresetn) // R11
    st.control[PGC_B_EXT_RESET] && st.control[PGC_B_INDEP_BASE] && !limit_mode_sel |=> ext_period_reset_on)
    else $error("external reset not taken");
  // R12: period changes only by a write
  period_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // R12
    !(st.wr_pend && st.wr_addr == PGC_OFS_SEC_PERIOD) |=> $stable(st.sec_period))
    else $error("secondary period changed without write");
  // R13: compare changes only by a write
  compare_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // R13
    !(st.wr_pend && st.wr_addr == PGC_OFS_SEC_COMPARE) |=> $stable(st.sec_compare))
    else $error("compare count changed without write");
  // R13: match flag on equal count
  match_hit_a: assert property (@(posedge hclk) disable iff (!hresetn) // R13
    secondary_master_timer == st.sec_compare |=> secondary_event_match)
    else $error("compare match missed");
  // R13: no match on unequal count
  match_miss_a: assert property (@(posedge hclk) disable iff (!hresetn) // R13
    secondary_master_timer != st.sec_compare |=> !secondary_event_match)
    else $error("compare match without equal count");
  // R14: code zero ties input 5 low
  in5_low_a: assert property (@(posedge hclk) disable iff (!hresetn) // R14
    st.comp_select[14:8] == PGC_SEL_TIED_LOW |=> !comp_in5)
    else $error("input 5 not tied low");
  // R14: code one routes comparator to input 5
  in5_cmp_a: assert property (@(posedge hclk) disable iff (!hresetn) // R14
    st.comp_select[14:8] == PGC_SEL_COMPARATOR |=> comp_in5 == $past(comparator_one))
    else $error("input 5 not on comparator");
  // R15: code zero ties input 4 low
  in4_low_a: assert property (@(posedge hclk) disable iff (!hresetn) // R15
    st.comp_select[6:0] == PGC_SEL_TIED_LOW |=> !comp_in4)
    else $error("input 4 not tied low");
  // R15: code one routes comparator to input 4
  in4_cmp_a: assert property (@(posedge hclk) disable iff (!hresetn) // R15
    st.comp_select[6:0] == PGC_SEL_COMPARATOR |=> comp_in4 == $past(comparator_one))
    else $error("input 4 not on comparator");
endmodule : pgc_top

/* File: hw/pgc_pkg.sv */
// package: register map, field layout and reset values of the pwm generator control block
package pgc_pkg;
  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] PGC_OFS_CONTROL = 8'h00;
  localparam logic [7:0] PGC_OFS_SEC_PERIOD = 8'h04;
  localparam logic [7:0] PGC_OFS_SEC_COMPARE = 8'h08;
  localparam logic [7:0] PGC_OFS_COMP_SELECT = 8'h0C;
  localparam logic [7:0] PGC_OFS_PERIODS = 8'h10;
  localparam logic [7:0] PGC_OFS_DUTIES = 8'h14;
  localparam logic [7:0] PGC_OFS_IRQ_MASK = 8'h18;
  localparam logic [7:0] PGC_OFS_MISC = 8'h1C;
  // ------------------------------------------------------------
  // generator control field positions
  // ------------------------------------------------------------
  localparam int PGC_B_FAULT_PEND = 15;
  localparam int PGC_B_LIMIT_PEND = 14;
  localparam int PGC_B_TRIG_PEND = 13;
  localparam int PGC_B_FAULT_IEN = 12;
  localparam int PGC_B_LIMIT_IEN = 11;
  localparam int PGC_B_TRIG_IEN = 10;
  localparam int PGC_B_INDEP_BASE = 9;
  localparam int PGC_B_MASTER_DUTY = 8;
  localparam int PGC_B_DT_HI = 7;
  localparam int PGC_B_DT_LO = 6;
  localparam int PGC_B_DT_POL = 5;
  localparam int PGC_B_MASTER_BASE = 3;
  localparam int PGC_B_CENTER = 2;
  localparam int PGC_B_EXT_RESET = 1;
  localparam int PGC_B_IMMED = 0;
  localparam logic [15:0] PGC_CTRL_WMASK = 16'h1FEF;
  localparam logic [1:0] PGC_DT_COMP_MODE = 2'h3;
  // ------------------------------------------------------------
  // reset values and constants
  // ------------------------------------------------------------
  localparam logic [15:0] PGC_RST_CONTROL = 16'h0000;
  localparam logic [15:0] PGC_RST_SEC_PERIOD = 16'hFFF8;
  localparam logic [15:0] PGC_RST_SEC_COMPARE = 16'h0000;
  localparam logic [15:0] PGC_RST_COMP_SELECT = 16'h0000;
  localparam logic [15:0] PGC_COMP_SEL_MASK = 16'h7F7F;
  localparam logic [6:0] PGC_SEL_TIED_LOW = 7'h00;
  localparam logic [6:0] PGC_SEL_COMPARATOR = 7'h01;
  localparam logic [6:0] PGC_SEL_REMAP_124 = 7'h7C;
  localparam logic [1:0] PGC_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] PGC_HSIZE_WORD = 3'h2;
endpackage : pgc_pkg

/* File: sim/pgc_irq_ctrl_model.sv */
// interrupt controller model at the far side of the block
`timescale 1ns/1ps
module pgc_irq_ctrl_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic irq,
  input wire logic trigger_irq_req,
  input wire logic flag_clear,
  output logic irq_flag,
  output logic [7:0] trig_count
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_flag <= 1'b0;
      trig_count <= 8'h00;
    end else begin
      if (irq) irq_flag <= 1'b1;
      else if (flag_clear) irq_flag <= 1'b0;
      if (trigger_irq_req) trig_count <= trig_count + 8'h01;
    end
  end
endmodule : pgc_irq_ctrl_model

/* File: sim/testbench.sv */
// self-checking bench for the pwm generator control block
`timescale 1ns/1ps
module testbench
  import pgc_pkg::*;
;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic fault_event = 0, limit_event = 0, trigger_event = 0, limit_mode_sel = 0;
  logic pwm_module_on = 0, comparator_one = 1, flag_clear = 0, irq_flag;
  logic [15:0] secondary_master_timer = '0, active_period, active_duty;
  logic [124:2] remap_inputs = '1;
  logic irq, trigger_irq_req, center_aligned_on, ext_period_reset_on;
  logic deadtime_polarity_eff, secondary_event_match, comp_in4, comp_in5;
  logic [7:0] trig_count;
  logic [6:0] c4, c5;
  logic [16:0] m;
  logic [6:0] codes [5] = '{7'h00, 7'h01, 7'h7C, 7'h05, 7'h7D};
  logic [16:0] modes [6] = '{17'h00000, 17'h00306, 17'h10306, 17'h00006, 17'h000A0, 17'h000E0};
  int n_mismatch = 0, tests_run = 0, cycles = 0;

  pgc_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .fault_event(fault_event), .limit_event(limit_event),
    .trigger_event(trigger_event), .limit_mode_sel(limit_mode_sel), .pwm_module_on(pwm_module_on),
    .secondary_master_timer(secondary_master_timer), .comparator_one(comparator_one),
    .remap_inputs(remap_inputs), .irq(irq), .trigger_irq_req(trigger_irq_req),
    .active_period(active_period), .active_duty(active_duty), .center_aligned_on(center_aligned_on),
    .ext_period_reset_on(ext_period_reset_on), .deadtime_polarity_eff(deadtime_polarity_eff),
    .secondary_event_match(secondary_event_match), .comp_in4(comp_in4), .comp_in5(comp_in5));

  pgc_irq_ctrl_model i_far (.hclk(hclk), .hresetn(hresetn), .irq(irq), .trigger_irq_req(trigger_irq_req),
    .flag_clear(flag_clear), .irq_flag(irq_flag), .trig_count(trig_count));

  initial forever #4 hclk = ~hclk;

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // single word transfer; waits on hready in both phases
  task ahb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= PGC_HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= PGC_HSIZE_WORD;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : ahb

  // idle edges let registered outputs settle before sampling
  task wr(input logic [7:0] a, input logic [31:0] d);
    ahb(a, 1'b1, d);
    repeat (2) @(posedge hclk);
  endtask : wr

  task rdc(input logic [7:0] a, input logic [31:0] exp);
    ahb(a, 1'b0, 32'h0);
    chk(rd, exp);
  endtask : rdc

  task ev(input logic [2:0] e);
    {fault_event, limit_event, trigger_event} <= e;
    @(posedge hclk);
    {fault_event, limit_event, trigger_event} <= 3'h0;
    repeat (2) @(posedge hclk);
  endtask : ev

  function automatic logic sel(input logic [6:0] c);
    if (c == 7'h00 || c > 7'h7C) return 1'b0;
    if (c == 7'h01) return comparator_one;
    return remap_inputs[c];
  endfunction : sel

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(PGC_OFS_CONTROL, 32'h0);
    rdc(PGC_OFS_SEC_PERIOD, 32'hFFF8);
    rdc(PGC_OFS_SEC_COMPARE, 32'h0);
    rdc(PGC_OFS_COMP_SELECT, 32'h0);
    wr(PGC_OFS_SEC_PERIOD, 32'hFFFF1234);
    rdc(PGC_OFS_SEC_PERIOD, 32'h1234);
    wr(PGC_OFS_SEC_COMPARE, 32'h0000ABCD);
    rdc(PGC_OFS_SEC_COMPARE, 32'hABCD);
    wr(PGC_OFS_COMP_SELECT, 32'hFFFF);
    rdc(PGC_OFS_COMP_SELECT, 32'h7F7F);
    wr(PGC_OFS_CONTROL, 32'hFFFF);
    rdc(PGC_OFS_CONTROL, 32'h1FEF);
    wr(8'h20, 32'hFFFF);
    rdc(8'h20, 32'h0);
    chk(32'(hresp), 32'h0);
    $display("test registers done");
    wr(PGC_OFS_SEC_COMPARE, 32'h55);
    secondary_master_timer <= 16'h0055;
    repeat (2) @(posedge hclk);
    chk(32'(secondary_event_match), 32'h1);
    secondary_master_timer <= 16'h0056;
    repeat (2) @(posedge hclk);
    chk(32'(secondary_event_match), 32'h0);
    $display("test compare done");
    remap_inputs[5] <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      c5 = codes[i];
      c4 = codes[(i + 1) % 5];
      wr(PGC_OFS_COMP_SELECT, {17'h0, c5, 1'b0, c4});
      chk(32'({comp_in5, comp_in4}), 32'({sel(c5), sel(c4)}));
    end
    $display("test selectors done");
    wr(PGC_OFS_PERIODS, 32'h11112222);
    wr(PGC_OFS_DUTIES, 32'h33334444);
    for (int i = 0; i < 6; i++) begin
      m = modes[i];
      limit_mode_sel <= m[16];
      wr(PGC_OFS_CONTROL, {16'h0, m[15:0]});
      chk(32'(active_period), m[9] ? 32'h1111 : 32'h2222);
      chk(32'(active_duty), m[8] ? 32'h3333 : 32'h4444);
      chk(32'({center_aligned_on, ext_period_reset_on, deadtime_polarity_eff}),
        32'({m[9] & m[2], m[9] & m[1] & !m[16], (m[7:6] == 2'h3) & m[5]}));
    end
    pwm_module_on <= 1'b1;
    @(posedge hclk);
    rdc(PGC_OFS_MISC, 32'h2);
    $display("test modes done");
    wr(PGC_OFS_CONTROL, 32'h0);
    ev(3'h7);
    rdc(PGC_OFS_CONTROL, 32'h0);
    wr(PGC_OFS_CONTROL, 32'h1C00);
    ev(3'h1);
    chk(32'(trig_count), 32'h1);
    rdc(PGC_OFS_CONTROL, 32'h3C00);
    chk(32'(irq), 32'h1);
    wr(PGC_OFS_IRQ_MASK, 32'h7);
    chk(32'(irq), 32'h0);
    wr(PGC_OFS_IRQ_MASK, 32'h0);
    ev(3'h6);
    rdc(PGC_OFS_CONTROL, 32'hFC00);
    chk(32'(irq_flag), 32'h1);
    wr(PGC_OFS_CONTROL, 32'h1800);
    rdc(PGC_OFS_CONTROL, 32'hD800);
    wr(PGC_OFS_CONTROL, 32'h0800);
    rdc(PGC_OFS_CONTROL, 32'h4800);
    wr(PGC_OFS_CONTROL, 32'h0);
    rdc(PGC_OFS_CONTROL, 32'h0);
    chk(32'(irq), 32'h0);
    flag_clear <= 1'b1;
    @(posedge hclk);
    flag_clear <= 1'b0;
    repeat (2) @(posedge hclk);
    chk(32'(irq_flag), 32'h0);
    $display("test interrupts done");
    report_and_stop();
  end
endmodule : testbench
